/* dv/motion_report_registers_tb_top.sv */
`timescale 1ns/100ps
module motion_report_registers_tb_top;
    import mrr_pkg::*;
    localparam int         ACC_W    = 12;
    localparam logic [7:0] PART_VAL = 8'h3c; // arbitrary value
    localparam logic [7:0] REV_VAL  = 8'h07; // arbitrary value
    localparam int         ACC_HI   = (1 << (ACC_W - 1)) - 1;
    localparam int         ACC_LO   = -(1 << (ACC_W - 1));

    logic               sys_clk       = 1'b0;
    logic               rst_b         = 1'b0;
    logic               cpi_sel       = 1'b0;
    logic               clk_en        = 1'b1;
    mrr_serial_in_t     serial_in;
    mrr_frame_motion_t  frame_motion  = '0;
    mrr_frame_quality_t frame_quality = '0;
    logic               miso_out;
    logic               miso_oe;
    int                 failures      = 0;
    int                 compares      = 0;
    int                 cycles        = 0;
    int                 ax            = 0;
    int                 ay            = 0;
    int                 fx            = 0;
    int                 fy            = 0;
    int                 f             = 0;
    logic               ovf           = 1'b0;
    logic [7:0]         st, xd, yd, rd;

    always #2 sys_clk = ~sys_clk;

    // cut a hang short: the run needs roughly 65k cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 95000) begin
            failures++;
            print_verdict();
        end
    end

    mrr_motion_report #(.ACC_W(ACC_W), .PART_ID(PART_VAL), .CHIP_REV(REV_VAL)) dut (
        .sys_clk               (sys_clk),
        .rst_b                 (rst_b),
        .clk_en                (clk_en),
        .serial_in             (serial_in),
        .miso_out              (miso_out),
        .miso_oe               (miso_oe),
        .counts_per_inch_select(cpi_sel),
        .frame_motion          (frame_motion),
        .frame_quality         (frame_quality)
    );

    mrr_host_model host (.serial_in(serial_in), .miso_out(miso_out), .miso_oe(miso_oe));

    task automatic print_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
        compares++;
        if (seen !== want) begin
            failures++;
            $display("FAIL %0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask : check

    function automatic int clamp(input int v, input int lo, input int hi);
        return (v > hi) ? hi : ((v < lo) ? lo : v);
    endfunction : clamp

    task automatic rd_reg(input logic [6:0] a, output logic [7:0] q);
        host.xfer({1'b0, a}, 8'h00, q);
    endtask : rd_reg

    // one frame of motion, mirrored into the reference accumulators
    task automatic move(input int dx, input int dy);
        @(negedge sys_clk);
        frame_motion = '{valid: 1'b1, dx: 8'(dx), dy: 8'(dy)};
        @(negedge sys_clk);
        frame_motion.valid = 1'b0;
        if (ax + dx != clamp(ax + dx, ACC_LO, ACC_HI)) ovf = 1'b1;
        if (ay + dy != clamp(ay + dy, ACC_LO, ACC_HI)) ovf = 1'b1;
        ax = clamp(ax + dx, ACC_LO, ACC_HI);
        ay = clamp(ay + dy, ACC_LO, ACC_HI);
    endtask : move

    // a status read loads saturated bytes and leaves the remainder behind
    task automatic freeze_model();
        fx = clamp(ax, -128, 127);
        fy = clamp(ay, -128, 127);
        ax -= fx;
        ay -= fy;
    endtask : freeze_model

    task automatic check_report();
        logic [7:0] exp_st;
        exp_st = {ax != 0 || ay != 0, 2'b00, ovf, 3'b000, cpi_sel};
        host.report(st, xd, yd);
        freeze_model();
        check(st, exp_st, "status");
        if (ax != ACC_LO && ax != ACC_HI && ay != ACC_LO && ay != ACC_HI) ovf = 1'b0;
        check(xd, 8'(fx), "x disp");
        check(yd, 8'(fy), "y disp");
    endtask : check_report

    initial begin
        void'($urandom(90));
        repeat (20) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (8) @(negedge sys_clk);
        // identity, reset values, unmapped and read-only places
        rd_reg(ADDR_PART_ID, rd);
        check(rd, PART_VAL, "part id");
        rd_reg(ADDR_CHIP_REV, rd);
        check(rd, REV_VAL, "revision");
        rd_reg(ADDR_SURF_QUAL, rd);
        check(rd, SQUAL_RESET, "squal reset");
        rd_reg(7'h07, rd);
        check(rd, UNMAPPED_READ, "unmapped");
        host.xfer({1'b1, ADDR_X_DISP}, 8'h55, rd);
        check_report();
        rd_reg(ADDR_PART_ID, rd);
        check(rd, PART_VAL, "part id again");
        $display("test ids done");
        // random motion, resolution and surface quality, with corner features
        for (int i = 0; i < 20; i++) begin
            @(negedge sys_clk);
            cpi_sel = 1'($urandom_range(1));
            repeat ($urandom_range(3)) move(int'($urandom_range(80)) - 40,
                                            int'($urandom_range(80)) - 40);
            f = (i == 0) ? 0 : ((i == 1) ? 1023 : int'($urandom_range(1023)));
            @(negedge sys_clk);
            frame_quality = '{valid: 1'b1, features: 10'(f)};
            @(negedge sys_clk);
            frame_quality.valid = 1'b0;
            rd_reg(ADDR_SURF_QUAL, rd);
            check(rd, ((f >> 2) > 169) ? SQUAL_MAX : 8'(f >> 2), "squal");
            if (i % 4 == 3) begin
                rd_reg(ADDR_STATUS, rd);
                freeze_model();
                move(int'($urandom_range(60)) - 30, 25);
            end
            check_report();
            if (i % 2 == 1) begin
                rd_reg(ADDR_X_DISP, rd);
                check(rd, 8'h00, "x cleared");
                rd_reg(ADDR_Y_DISP, rd);
                check(rd, 8'h00, "y cleared");
            end
        end
        $display("test random done");
        // overflow at the negative rail, then drain within 16 report cycles
        @(negedge sys_clk);
        cpi_sel = 1'b0;
        repeat (17) move(-128, 100);
        repeat (16) check_report();
        check_report();
        $display("test overflow done");
        // motion clear discards the accumulators and the frozen pair
        move(50, -30);
        rd_reg(ADDR_STATUS, rd);
        freeze_model();
        move(90, -70);
        host.xfer({1'b1, ADDR_MOT_CLEAR}, 8'($urandom), rd);
        ax = 0;
        ay = 0;
        ovf = 1'b0;
        rd_reg(ADDR_X_DISP, rd);
        check(rd, 8'h00, "x after clear");
        // motion offered while the clock enable is low must leave no trace
        @(negedge sys_clk);
        clk_en = 1'b0;
        frame_motion = '{valid: 1'b1, dx: 8'h11, dy: 8'h22};
        repeat (3) @(negedge sys_clk);
        frame_motion.valid = 1'b0;
        clk_en = 1'b1;
        check_report();
        $display("test clear done");
        print_verdict();
    end
endmodule : motion_report_registers_tb_top

/* dv/mrr_host_model.sv */
`timescale 1ns/100ps
module mrr_host_model
    import mrr_pkg::*;
(
    output mrr_serial_in_t serial_in,
    input  wire logic      miso_out,
    input  wire logic      miso_oe
);
    // sclk stands still low and the chip is deselected between frames
    initial begin
        serial_in = '{ncs_b: 1'b1, sclk: 1'b0, mosi: 1'b0};
    end

    // one framed access: address byte then data byte, msb first, 80 ns sclk
    task automatic xfer(input logic [7:0] addr_byte, input logic [7:0] wdata,
                        output logic [7:0] rdata);
        logic [15:0] frame;
        frame = {addr_byte, wdata};
        rdata = 8'h00;
        #1.3; // keeps sclk edges away from the sys_clk edges
        serial_in.ncs_b = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            serial_in.mosi = frame[i];
            #40 serial_in.sclk = 1'b1;
            if (i < 8) rdata[i] = miso_oe ? miso_out : !miso_out; // undriven line reads inverted
            #40 serial_in.sclk = 1'b0;
        end
        #40 serial_in.ncs_b = 1'b1;
        serial_in.mosi = ~serial_in.mosi; // a released line must not keep the last bit
        #198.7; // a whole frame is 380 sys_clk periods, so sclk edges never drift onto them
    endtask : xfer

    // one report cycle, status first so the displacement pair is frozen
    task automatic report(output logic [7:0] st, output logic [7:0] xd, output logic [7:0] yd);
        xfer({1'b0, ADDR_STATUS}, 8'h00, st);
        xfer({1'b0, ADDR_X_DISP}, 8'h00, xd);
        xfer({1'b0, ADDR_Y_DISP}, 8'h00, yd);
    endtask : report
endmodule : mrr_host_model

/* hw/mrr_motion_report.sv */
`timescale 1ns/100ps
module mrr_motion_report
    import mrr_pkg::*;
#(
    parameter int         ACC_W       = 12,
    parameter logic [7:0] PART_ID     = 8'h5a, // arbitrary value
    parameter logic [7:0] CHIP_REV    = 8'h01  // arbitrary value
) (
    input  wire logic               sys_clk,
    input  wire logic               rst_b,
    input  wire logic               clk_en,
    input  wire mrr_serial_in_t     serial_in,
    output logic                    miso_out,
    output logic                    miso_oe,
    input  wire logic               counts_per_inch_select,
    input  wire mrr_frame_motion_t  frame_motion,
    input  wire mrr_frame_quality_t frame_quality
);

    localparam logic signed [ACC_W-1:0] ACC_MAX = {1'b0, {(ACC_W-1){1'b1}}};
    localparam logic signed [ACC_W-1:0] ACC_MIN = {1'b1, {(ACC_W-1){1'b0}}};
    localparam logic signed [ACC_W-1:0] S8_MAX  = ACC_W'(127);
    localparam logic signed [ACC_W-1:0] S8_MIN  = -ACC_W'(128);

    // saturate an accumulator to the 8-bit signed range
    function automatic logic [7:0] sat8(input logic signed [ACC_W-1:0] v);
        if (v > S8_MAX) begin
            sat8 = 8'h7f;
        end else if (v < S8_MIN) begin
            sat8 = 8'h80;
        end else begin
            sat8 = v[7:0];
        end
    endfunction : sat8

    // add a frame delta into a sum one bit wider, so the caller can detect overflow
    function automatic logic signed [ACC_W:0] acc_add(input logic signed [ACC_W-1:0] a,
                                                      input logic signed [7:0]       d);
        logic signed [ACC_W:0] s;
        s = {a[ACC_W-1], a} + {{(ACC_W-7){d[7]}}, d};
        acc_add = s;
    endfunction : acc_add

    function automatic logic at_rail(input logic signed [ACC_W-1:0] v);
        at_rail = (v == ACC_MAX) || (v == ACC_MIN);
    endfunction : at_rail

    // two-stage synchronisers; sclk has one more stage for edge finding, the third ncs stage is unused
    logic [2:0] ncs_sync_reg;
    logic [2:0] sclk_sync_reg;
    logic [1:0] mosi_sync_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ncs_sync_reg  <= 3'h7;
            sclk_sync_reg <= 3'h0;
            mosi_sync_reg <= 2'h0;
        end else if (clk_en) begin
            ncs_sync_reg  <= {ncs_sync_reg[1:0], serial_in.ncs_b};
            sclk_sync_reg <= {sclk_sync_reg[1:0], serial_in.sclk};
            mosi_sync_reg <= {mosi_sync_reg[0], serial_in.mosi};
        end
    end

    logic sel;
    logic sclk_rise;
    logic sclk_fall;
    assign sel       = !ncs_sync_reg[1];
    assign sclk_rise = clk_en && sel && sclk_sync_reg[1] && !sclk_sync_reg[2];
    assign sclk_fall = clk_en && sel && !sclk_sync_reg[1] && sclk_sync_reg[2];

    // serial shifter: address byte then one data byte
    mrr_serial_state_t sp_state_reg;
    logic [3:0]        bit_cnt_reg;
    logic [7:0]        rx_reg;
    logic [7:0]        tx_reg;
    logic [6:0]        addr_reg;
    logic              is_write_reg;
    logic [7:0]        rx_full;
    logic              addr_done;
    logic              data_done;

    assign rx_full   = {rx_reg[6:0], mosi_sync_reg[1]};
    assign addr_done = sclk_rise && sp_state_reg == SP_ADDR && bit_cnt_reg == BIT_CNT_MAX - 4'h1;
    assign data_done = sclk_rise && sp_state_reg == SP_DATA && bit_cnt_reg == BIT_CNT_MAX - 4'h1;

    // register access strobes, one sys_clk cycle each
    logic rd_status;
    logic rd_x;
    logic rd_y;
    logic wr_mclear;
    assign rd_status = addr_done && !rx_full[WR_FLAG_BIT] && rx_full[6:0] == ADDR_STATUS;
    assign rd_x      = addr_done && !rx_full[WR_FLAG_BIT] && rx_full[6:0] == ADDR_X_DISP;
    assign rd_y      = addr_done && !rx_full[WR_FLAG_BIT] && rx_full[6:0] == ADDR_Y_DISP;
    assign wr_mclear = data_done && is_write_reg && addr_reg == ADDR_MOT_CLEAR;

    always_ff @(posedge sys_clk) begin
        if (!rst_b || (clk_en && !sel)) begin
            sp_state_reg <= SP_ADDR;
            bit_cnt_reg  <= 4'h0;
            rx_reg       <= 8'h00;
            addr_reg     <= 7'h00;
            is_write_reg <= 1'b0;
        end else if (sclk_rise) begin
            rx_reg <= rx_full;
            if (bit_cnt_reg == BIT_CNT_MAX - 4'h1) begin
                bit_cnt_reg <= 4'h0;
                if (sp_state_reg == SP_ADDR) begin
                    addr_reg     <= rx_full[6:0];
                    is_write_reg <= rx_full[WR_FLAG_BIT];
                    sp_state_reg <= SP_DATA;
                end else begin
                    sp_state_reg <= SP_ADDR; // a further byte starts a new access
                end
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end
    end

    // accumulators and frozen displacement values
    logic signed [ACC_W-1:0] acc_x_reg;
    logic signed [ACC_W-1:0] acc_y_reg;
    logic [7:0]              x_disp_reg;
    logic [7:0]              y_disp_reg;
    logic                    ovf_reg;
    logic [7:0]              squal_reg;

    logic [7:0]              snap_x;
    logic [7:0]              snap_y;
    logic signed [ACC_W-1:0] base_x;
    logic signed [ACC_W-1:0] base_y;
    logic signed [ACC_W:0]   sum_x;
    logic signed [ACC_W:0]   sum_y;
    logic                    ovf_x;
    logic                    ovf_y;
    logic                    mot_now;

    always_comb begin
        snap_x = sat8(acc_x_reg);
        snap_y = sat8(acc_y_reg);
        base_x = rd_status ? acc_x_reg - {{(ACC_W-8){snap_x[7]}}, snap_x} : acc_x_reg;
        base_y = rd_status ? acc_y_reg - {{(ACC_W-8){snap_y[7]}}, snap_y} : acc_y_reg;
        sum_x  = acc_add(base_x, frame_motion.valid ? frame_motion.dx : 8'sh00);
        sum_y  = acc_add(base_y, frame_motion.valid ? frame_motion.dy : 8'sh00);
        ovf_x  = sum_x[ACC_W] != sum_x[ACC_W-1];
        ovf_y  = sum_y[ACC_W] != sum_y[ACC_W-1];
    end

    // motion pending means an accumulator still holds counts
    assign mot_now = (acc_x_reg != '0) || (acc_y_reg != '0);

    // accumulators clip at the rails so a long idle host sees full scale reads
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            acc_x_reg <= '0;
            acc_y_reg <= '0;
        end else if (clk_en) begin
            if (wr_mclear) begin
                acc_x_reg <= '0;
                acc_y_reg <= '0;
            end else begin
                acc_x_reg <= ovf_x ? (sum_x[ACC_W] ? ACC_MIN : ACC_MAX) : sum_x[ACC_W-1:0];
                acc_y_reg <= ovf_y ? (sum_y[ACC_W] ? ACC_MIN : ACC_MAX) : sum_y[ACC_W-1:0];
            end
        end
    end

    // a status read overwrites any unread frozen values, a read clears its own
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            x_disp_reg <= DISP_RESET;
            y_disp_reg <= DISP_RESET;
        end else if (clk_en) begin
            if (wr_mclear) begin
                x_disp_reg <= DISP_RESET;
                y_disp_reg <= DISP_RESET;
            end else if (rd_status) begin
                x_disp_reg <= snap_x;
                y_disp_reg <= snap_y;
            end else begin
                if (rd_x) begin
                    x_disp_reg <= DISP_RESET;
                end
                if (rd_y) begin
                    y_disp_reg <= DISP_RESET;
                end
            end
        end
    end

    // overflow is sticky; a new overflow in the clearing cycle wins
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ovf_reg <= 1'b0;
        end else if (clk_en) begin
            if (ovf_x || ovf_y) begin
                ovf_reg <= 1'b1;
            end else if (wr_mclear) begin
                ovf_reg <= 1'b0;
            end else if ((rd_x || rd_y) && !at_rail(acc_x_reg) && !at_rail(acc_y_reg)) begin
                ovf_reg <= 1'b0;
            end
        end
    end

    // surface quality drops the two low bits and is clipped at the ceiling
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            squal_reg <= SQUAL_RESET;
        end else if (clk_en && frame_quality.valid) begin
            if (frame_quality.features[9:2] > SQUAL_MAX) begin
                squal_reg <= SQUAL_MAX;
            end else begin
                squal_reg <= frame_quality.features[9:2];
            end
        end
    end

    // read data, captured at the end of the address byte
    logic [7:0] rd_data;
    always_comb begin
        case (rx_full[6:0])
            ADDR_PART_ID:   rd_data = PART_ID;
            ADDR_CHIP_REV:  rd_data = CHIP_REV;
            ADDR_STATUS: begin
                rd_data               = 8'h00;
                rd_data[STAT_MOT_BIT] = mot_now;
                rd_data[STAT_OVF_BIT] = ovf_reg || ovf_x || ovf_y;
                rd_data[STAT_RES_BIT] = counts_per_inch_select;
            end
            ADDR_X_DISP:    rd_data = x_disp_reg;
            ADDR_Y_DISP:    rd_data = y_disp_reg;
            ADDR_SURF_QUAL: rd_data = squal_reg;
            default:        rd_data = UNMAPPED_READ;
        endcase
    end

    // first bit is presented at once, later bits move on falling sclk
    logic tx_active_reg;
    always_ff @(posedge sys_clk) begin
        if (!rst_b || (clk_en && !sel)) begin
            tx_reg        <= 8'h00;
            tx_active_reg <= 1'b0;
        end else if (addr_done) begin
            tx_reg        <= rx_full[WR_FLAG_BIT] ? 8'h00 : rd_data;
            tx_active_reg <= !rx_full[WR_FLAG_BIT];
        end else if (sclk_fall && sp_state_reg == SP_DATA && bit_cnt_reg != 4'h0) begin
            tx_reg <= {tx_reg[6:0], 1'b0};
        end else if (data_done) begin
            tx_active_reg <= 1'b0;
        end
    end

    assign miso_out = tx_reg[BYTE_BITS-1];
    assign miso_oe  = tx_active_reg;

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sequence status_read_s;
        rd_status && !wr_mclear;
    endsequence

    sequence x_read_s;
        rd_x && !wr_mclear;
    endsequence

    // identity bytes never depend on any state
    part_id_fixed_a: assert property (
        addr_done && rx_full == {1'b0, ADDR_PART_ID} |=> tx_reg == PART_ID)
        else $error("part identifier read wrong");
    chip_rev_fixed_a: assert property (
        addr_done && rx_full == {1'b0, ADDR_CHIP_REV} |=> tx_reg == CHIP_REV)
        else $error("chip revision read wrong");

    // the status byte is taken before the freeze removes the reported counts
    status_bits_a: assert property (
        status_read_s |=> tx_reg[STAT_MOT_BIT] == $past(mot_now)
                          && tx_reg[STAT_RES_BIT] == $past(counts_per_inch_select))
        else $error("status motion or resolution bit wrong");
    status_ovf_a: assert property (
        rd_status && ovf_reg |=> tx_reg[STAT_OVF_BIT])
        else $error("status overflow bit missing");
    read_drive_a: assert property (
        addr_done && !rx_full[WR_FLAG_BIT] |=> miso_oe)
        else $error("read data not driven");

    // freeze loads saturated bytes, then holds them against later frames
    freeze_load_a: assert property (
        status_read_s |=> x_disp_reg == sat8($past(acc_x_reg))
                          && y_disp_reg == sat8($past(acc_y_reg)))
        else $error("frozen displacement not saturated snapshot");
    freeze_hold_a: assert property (
        status_read_s ##1 (clk_en && !rd_status && !rd_x && !wr_mclear)
        |=> x_disp_reg == $past(x_disp_reg))
        else $error("frozen x displacement changed");
    freeze_hold_y_a: assert property (
        status_read_s ##1 (clk_en && !rd_status && !rd_y && !wr_mclear)
        |=> y_disp_reg == $past(y_disp_reg))
        else $error("frozen y displacement changed");

    // reading a displacement register empties it
    x_read_clear_a: assert property (
        x_read_s |=> x_disp_reg == DISP_RESET)
        else $error("x displacement not cleared by read");
    y_read_clear_a: assert property (
        rd_y && !rd_status && !wr_mclear |=> y_disp_reg == DISP_RESET)
        else $error("y displacement not cleared by read");

    // a fresh overflow in the clearing cycle keeps the flag, since set wins
    motion_clear_a: assert property (
        wr_mclear |=> acc_x_reg == '0 && acc_y_reg == '0
                      && (!ovf_reg || $past(ovf_x || ovf_y)))
        else $error("motion clear left counts");
    ovf_set_a: assert property (
        clk_en && (ovf_x || ovf_y)
        |=> ovf_reg ##1 (ovf_reg || $past(rd_x || rd_y || wr_mclear)))
        else $error("overflow flag not set");
    ovf_clear_a: assert property (
        x_read_s ##0 (!ovf_x && !ovf_y && !at_rail(acc_x_reg) && !at_rail(acc_y_reg))
        |=> !ovf_reg)
        else $error("overflow flag not cleared by read");
    rail_clip_a: assert property (
        clk_en && ovf_x && !wr_mclear |=> at_rail(acc_x_reg))
        else $error("x accumulator not held at full scale");
    mot_idle_a: assert property (
        clk_en && !mot_now && !frame_motion.valid |=> !mot_now)
        else $error("motion flag set without motion");

    // surface quality: straight copy below the ceiling, never above it
    squal_ceiling_a: assert property (
        squal_reg <= SQUAL_MAX)
        else $error("surface quality above ceiling");
    squal_load_a: assert property (
        clk_en && frame_quality.valid && frame_quality.features[9:2] <= SQUAL_MAX
        |=> squal_reg == $past(frame_quality.features[9:2]))
        else $error("surface quality not loaded");

    // a low clock enable must freeze the motion state completely
    enable_freeze_a: assert property (
        !clk_en |=> $stable(acc_x_reg) && $stable(acc_y_reg) && $stable(ovf_reg))
        else $error("state moved while clock enable low");

endmodule : mrr_motion_report

/* hw/mrr_pkg.sv */
// Overview of operation
// - part identifier register returns one fixed byte forever, confirming the serial link.
// - chip revision register returns a fixed read-only 8-bit revision value.
// - status bit 7 reads 1 while motion is pending since last report.
// - status bit 4 reads 1 when an accumulator overflowed since last report.
// - status bit 0 shows resolution: 0 for 400 cpi, 1 for 800 cpi.
// - status read freezes the X and Y displacement registers until read.
// - second status read before displacement reads discards the earlier frozen values.
// - accumulators are wider than 8 bits; overflow loses data and sets flag.
// - overflow flag clears after a displacement read once accumulators are not full.
// - after overflow a displacement reads full scale; host repeats reads until clear.
// - any write to the motion-clear register discards all accumulated motion.
// - X displacement is 8-bit two's complement counts; reading clears it.
// - Y displacement is 8-bit two's complement counts; reading clears it.
// - surface quality shows upper eight bits of a 10-bit feature count.
// - surface quality never exceeds 169 and may change every frame.
// - surface quality near zero when no surface lies below the sensor.
package mrr_pkg;
    // register map
    localparam logic [6:0] ADDR_PART_ID   = 7'h00;
    localparam logic [6:0] ADDR_CHIP_REV  = 7'h01;
    localparam logic [6:0] ADDR_STATUS    = 7'h02;
    localparam logic [6:0] ADDR_X_DISP    = 7'h03;
    localparam logic [6:0] ADDR_Y_DISP    = 7'h04;
    localparam logic [6:0] ADDR_SURF_QUAL = 7'h05;
    localparam logic [6:0] ADDR_MOT_CLEAR = 7'h12;

    // status field positions
    localparam int STAT_MOT_BIT = 7;
    localparam int STAT_OVF_BIT = 4;
    localparam int STAT_RES_BIT = 0;

    // serial framing: address byte, bit 7 high marks a write
    localparam int             BYTE_BITS  = 8;
    localparam int             WR_FLAG_BIT = 7;
    localparam logic [3:0]     BIT_CNT_MAX = 4'h8;

    // reset and limit values
    localparam logic [7:0] DISP_RESET    = 8'h00;
    localparam logic [7:0] SQUAL_RESET   = 8'h00;
    localparam logic [7:0] SQUAL_MAX     = 8'ha9;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // serial pins coming from the host, all asynchronous to sys_clk
    typedef struct packed {
        logic ncs_b;
        logic sclk;
        logic mosi;
    } mrr_serial_in_t;

    // one frame's worth of measured displacement from the navigation engine
    typedef struct packed {
        logic              valid;
        logic signed [7:0] dx;
        logic signed [7:0] dy;
    } mrr_frame_motion_t;

    // per-frame image statistics
    typedef struct packed {
        logic       valid;
        logic [9:0] features;
    } mrr_frame_quality_t;

    typedef enum logic {
        SP_ADDR,
        SP_DATA
    } mrr_serial_state_t;
endpackage : mrr_pkg
